//--- core/csc_core.sv
// Configurable SPI controller: master or slave, four frame formats,
// 8-word (16 in packed byte mode) RX and TX FIFOs, event sources and DMA level requests.
// Assumes all inputs synchronous to core_clk; pins split into
// in/out/enable, the wire level is resolved outside.
`timescale 1ns/100ps

module csc_core (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic master_mode,
    input wire logic [1:0] frame_fmt,
    input wire logic clk_phase,
    input wire logic clk_polarity,
    input wire logic [7:0] oversample,
    input wire logic late_rx_sample_en,
    input wire logic deep_sleep_wake_en,
    input wire logic [4:0] rx_width,
    input wire logic [4:0] tx_width,
    input wire logic lsb_first,
    input wire logic word_gap_select_release,
    input wire logic packed_byte_fifo_en,
    input wire logic continuous_serial_clock_en,
    input wire logic [3:0] select_level_mask,
    input wire logic [1:0] active_select,
    input wire logic [4:0] rx_threshold,
    input wire logic [4:0] tx_threshold,
    input wire logic [5:0] rx_event_mask,
    input wire logic [5:0] tx_event_mask,
    input wire logic [5:0] rx_event_clear,
    input wire logic [5:0] tx_event_clear,
    input wire logic tx_wr_req,
    input wire logic [15:0] tx_wr_data,
    input wire logic rx_rd_req,
    output logic [15:0] rx_rd_data,
    output logic rx_rd_valid,
    output logic tx_full,
    output logic [4:0] tx_count,
    output logic [4:0] rx_count,
    output logic [5:0] rx_events,
    output logic [5:0] tx_events,
    output logic rx_dma_request,
    output logic tx_dma_request,
    output logic bus_busy,
    output logic wake_request,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic select_in,
    output logic [3:0] select_out,
    output logic select_oe
);

    // ==============================================================
    // Configuration decode
    csc_pkg::csc_regs_type q;
    csc_pkg::csc_regs_type d;
    logic is_classic, is_hd, is_tic, is_tip, sel_held;
    logic cpol_e, cpha_e, din, sel_act_in;
    logic [7:0] ovs_e, half_m1;
    logic [5:0] total;
    logic [4:0] cap;
    logic tx_empty, sedge, slead, strail, smp, lau, act_rise;
    logic tick, bit_start, mid, load_word, rx_push, tx_pop;
    logic tx_push_ok, sel_on, sclk_run;
    logic [15:0] rx_val;
    logic [2:0] rx_set, tx_set;
    logic [5:0] rx_lvl, tx_lvl;

    // Formats and the effective clock mode
    assign is_classic = frame_fmt == csc_pkg::CSC_FMT_CLASSIC;
    assign is_hd = frame_fmt == csc_pkg::CSC_FMT_HALF_DUPLEX;
    assign is_tic = frame_fmt == csc_pkg::CSC_FMT_PULSE_COINCIDENT;
    assign is_tip = frame_fmt == csc_pkg::CSC_FMT_PULSE_PRECEDING;
    assign sel_held = is_classic | is_hd;
    // Pulse and half duplex frames launch on rise, sample on fall
    assign cpol_e = is_classic ? clk_polarity : 1'b0;
    assign cpha_e = is_classic ? clk_phase : 1'b1;
    assign din = master_mode ? miso_in : mosi_in;
    assign sel_act_in = select_in == select_level_mask[0];
    // Odd factors round down to an even bit period
    assign ovs_e = (oversample < csc_pkg::CSC_OVS_MIN) ?
                   csc_pkg::CSC_OVS_MIN : oversample;
    assign half_m1 = {1'b0, ovs_e[7:1]} - 8'h01;
    assign total = is_hd ? ({1'b0, tx_width} + {1'b0, rx_width}) :
                   {1'b0, tx_width};
    assign cap = packed_byte_fifo_en ? csc_pkg::CSC_DEPTH_BYTES :
                 csc_pkg::CSC_DEPTH_WORDS;
    assign tx_empty = q.tx_cnt == 5'h00;

    // Slave edge detection on the sampled serial clock
    assign sedge = sclk_in != q.sclk_prev;
    assign slead = sedge & (q.sclk_prev == cpol_e);
    assign strail = sedge & (q.sclk_prev != cpol_e);
    assign smp = cpha_e ? strail : slead;
    assign lau = cpha_e ? slead : strail;
    assign act_rise = sel_act_in & ~q.sel_prev;

    // ==============================================================
    // Bit helpers: which bits carry data and where they sit
    function automatic logic tx_bit(input logic [5:0] k);
        if (!is_hd) begin
            tx_bit = 1'b1;
        end else if (master_mode) begin
            tx_bit = k < {1'b0, tx_width};
        end else begin
            tx_bit = k >= {1'b0, rx_width};
        end
    endfunction

    function automatic logic rx_bit(input logic [5:0] k);
        if (!is_hd) begin
            rx_bit = 1'b1;
        end else if (master_mode) begin
            rx_bit = k >= {1'b0, tx_width};
        end else begin
            rx_bit = k < {1'b0, rx_width};
        end
    endfunction

    function automatic logic [3:0] tx_idx(input logic [5:0] k);
        logic [5:0] j;
        logic [4:0] t;
        j = (is_hd && !master_mode) ? k - {1'b0, rx_width} : k;
        t = tx_width - 5'h01 - j[4:0];
        tx_idx = lsb_first ? j[3:0] : t[3:0];
    endfunction

    function automatic logic [3:0] rx_idx(input logic [5:0] k);
        logic [5:0] j;
        logic [4:0] t;
        j = (is_hd && master_mode) ? k - {1'b0, tx_width} : k;
        t = rx_width - 5'h01 - j[4:0];
        rx_idx = lsb_first ? j[3:0] : t[3:0];
    endfunction

    // Only the low TX-width bits of the entry are ever sent
    function automatic logic out_bit(input logic [15:0] w,
                                     input logic [5:0] k);
        out_bit = tx_bit(k) ? w[tx_idx(k)] : 1'b0;
    endfunction

    function automatic logic [15:0] rx_ins(input logic [15:0] w,
                                           input logic [5:0] k);
        rx_ins = w;
        if (rx_bit(k)) begin
            rx_ins[rx_idx(k)] = din;
        end
    endfunction

    // ==============================================================
    // Next state
    always_comb begin
        d = q;
        tick = 1'b0;
        load_word = 1'b0;
        rx_push = 1'b0;
        tx_pop = 1'b0;
        rx_val = q.rx_word;
        rx_set = 3'h0;
        tx_set = 3'h0;
        d.rd_valid = 1'b0;
        d.sclk_prev = sclk_in;
        d.sel_prev = sel_act_in;
        // Wake only from a slave select activation
        d.wake = ~master_mode & deep_sleep_wake_en & act_rise;
        // Bit clock divider, also the free running clock source
        if (enable && master_mode) begin
            if (q.div >= half_m1) begin
                d.div = 8'h00;
                tick = 1'b1;
            end else begin
                d.div = q.div + 8'h01;
            end
        end else begin
            d.div = 8'h00;
            d.ph = 1'b0;
        end
        if (tick) begin
            d.ph = ~q.ph;
        end
        bit_start = tick & q.ph;
        mid = tick & ~q.ph;
        if (!enable) begin
            d.st = csc_pkg::ST_IDLE;
        end else if (master_mode) begin
            unique case (q.st)
                // Words start on a bit boundary, never on the write
                csc_pkg::ST_IDLE: begin
                    if (bit_start && !tx_empty) begin
                        if (is_tic) begin
                            load_word = 1'b1;
                            d.st = csc_pkg::ST_SHIFT;
                        end else begin
                            d.st = csc_pkg::ST_LEAD;
                        end
                    end
                end
                csc_pkg::ST_LEAD: begin
                    if (bit_start) begin
                        load_word = 1'b1;
                        d.st = csc_pkg::ST_SHIFT;
                    end
                end
                csc_pkg::ST_SHIFT: begin
                    if (mid && !late_rx_sample_en) begin
                        d.rx_word = rx_ins(q.rx_word, q.bitcnt);
                        d.bitcnt = q.bitcnt + 6'h01;
                    end
                    if (bit_start) begin
                        if (late_rx_sample_en) begin
                            d.rx_word = rx_ins(q.rx_word, q.bitcnt);
                            d.bitcnt = q.bitcnt + 6'h01;
                        end
                        if (d.bitcnt >= total) begin
                            rx_push = 1'b1;
                            rx_val = d.rx_word;
                            if (!tx_empty && !word_gap_select_release) begin
                                if (is_tip) begin
                                    d.st = csc_pkg::ST_LEAD;
                                end else begin
                                    load_word = 1'b1;
                                end
                            end else if (!tx_empty) begin
                                d.st = csc_pkg::ST_GAP;
                            end else begin
                                d.st = csc_pkg::ST_IDLE;
                                tx_set[2] = 1'b1;
                            end
                        end else begin
                            d.dout = out_bit(q.tx_word, d.bitcnt);
                        end
                    end
                end
                csc_pkg::ST_GAP: begin
                    if (bit_start) begin
                        d.st = csc_pkg::ST_IDLE;
                    end
                end
            endcase
        end else if (sel_held && !sel_act_in) begin
            // Losing select mid word drops the partial word
            if (q.st == csc_pkg::ST_SHIFT && q.bitcnt != 6'h00) begin
                rx_set[2] = 1'b1;
            end
            d.st = csc_pkg::ST_IDLE;
        end else begin
            unique case (q.st)
                csc_pkg::ST_IDLE: begin
                    if ((sel_held && act_rise) ||
                        (is_tic && lau && sel_act_in)) begin
                        load_word = 1'b1;
                        d.st = csc_pkg::ST_SHIFT;
                    end else if (is_tip && smp && sel_act_in) begin
                        d.st = csc_pkg::ST_LEAD;
                    end
                end
                csc_pkg::ST_LEAD: begin
                    if (lau) begin
                        load_word = 1'b1;
                        d.st = csc_pkg::ST_SHIFT;
                    end
                end
                csc_pkg::ST_SHIFT: begin
                    if (smp) begin
                        d.rx_word = rx_ins(q.rx_word, q.bitcnt);
                        d.bitcnt = q.bitcnt + 6'h01;
                        if (d.bitcnt >= total) begin
                            rx_push = 1'b1;
                            rx_val = d.rx_word;
                            if (sel_held) begin
                                load_word = 1'b1;
                            end else begin
                                d.st = csc_pkg::ST_IDLE;
                            end
                        end
                    end else if (lau) begin
                        d.dout = out_bit(q.tx_word, q.bitcnt);
                    end
                end
                csc_pkg::ST_GAP: begin
                    d.st = csc_pkg::ST_IDLE;
                end
            endcase
        end
        // Word load; a slave with nothing queued sends zeros
        if (load_word) begin
            d.tx_word = tx_empty ? 16'h0000 : q.txm[q.tx_rp];
            tx_pop = ~tx_empty;
            tx_set[1] = tx_empty;
            d.bitcnt = 6'h00;
            d.rx_word = 16'h0000;
            d.dout = out_bit(d.tx_word, 6'h00);
        end
        // Host side of both FIFOs
        tx_push_ok = tx_wr_req & ~q.tx_full;
        tx_set[0] = tx_wr_req & q.tx_full;
        if (tx_push_ok) begin
            d.txm[q.tx_wp] = tx_wr_data;
            d.tx_wp = q.tx_wp + 4'h1;
        end
        if (tx_pop) begin
            d.tx_rp = q.tx_rp + 4'h1;
        end
        d.tx_cnt = q.tx_cnt + {4'h0, tx_push_ok} - {4'h0, tx_pop};
        if (rx_rd_req && q.rx_cnt == 5'h00) begin
            rx_set[1] = 1'b1;
        end else if (rx_rd_req) begin
            d.rd_data = q.rxm[q.rx_rp];
            d.rd_valid = 1'b1;
            d.rx_rp = q.rx_rp + 4'h1;
        end
        if (packed_byte_fifo_en) begin
            rx_val = {8'h00, rx_val[7:0]};
        end
        if (rx_push && q.rx_cnt == cap) begin
            rx_set[0] = 1'b1;
        end else if (rx_push) begin
            d.rxm[q.rx_wp] = rx_val;
            d.rx_wp = q.rx_wp + 4'h1;
        end
        d.rx_cnt = q.rx_cnt + {4'h0, rx_push && q.rx_cnt != cap} -
                   {4'h0, d.rd_valid};
        d.tx_full = d.tx_cnt >= cap;
        // Sticky flags: a set in the clearing cycle survives
        d.rx_stk = (q.rx_stk & ~rx_event_clear[5:3]) | rx_set;
        d.tx_stk = (q.tx_stk & ~tx_event_clear[5:3]) | tx_set;
        rx_lvl = {d.rx_stk, d.rx_cnt == cap, d.rx_cnt != 5'h00,
                  d.rx_cnt > rx_threshold};
        tx_lvl = {d.tx_stk, d.tx_cnt == 5'h00, d.tx_cnt < cap,
                  d.tx_cnt < tx_threshold};
        d.rx_ev = rx_lvl & rx_event_mask;
        d.tx_ev = tx_lvl & tx_event_mask;
        d.rx_dma = rx_lvl[csc_pkg::CSC_EV_LEVEL];
        d.tx_dma = tx_lvl[csc_pkg::CSC_EV_LEVEL];
        // Pins and bus status
        sel_on = (sel_held && d.st == csc_pkg::ST_SHIFT) ||
                 (!is_tic && d.st == csc_pkg::ST_LEAD) ||
                 (is_tic && d.st == csc_pkg::ST_SHIFT &&
                  d.bitcnt == 6'h00);
        sel_on = sel_on & enable & master_mode;
        d.sel_o = select_level_mask ^
                  ~({4{sel_on}} & (4'h1 << active_select));
        d.sel_oe = enable & master_mode;
        sclk_run = enable & master_mode & (continuous_serial_clock_en ||
                   d.st == csc_pkg::ST_SHIFT ||
                   (is_tip && d.st == csc_pkg::ST_LEAD));
        d.sclk_o = sclk_run ? (cpol_e ^ d.ph ^ cpha_e) : cpol_e;
        d.sclk_oe = enable & master_mode;
        d.mosi_oe = enable & master_mode;
        d.miso_oe = enable & ~master_mode &
                    (sel_held ? sel_act_in : d.st != csc_pkg::ST_IDLE);
        if (master_mode) begin
            d.busy = enable & (d.st == csc_pkg::ST_LEAD ||
                               d.st == csc_pkg::ST_SHIFT);
        end else begin
            d.busy = enable & (sel_held ? sel_act_in :
                               d.st != csc_pkg::ST_IDLE);
        end
    end

    // ==============================================================
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= csc_pkg::CSC_REGS_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign rx_rd_data = q.rd_data;
    assign rx_rd_valid = q.rd_valid;
    assign tx_full = q.tx_full;
    assign tx_count = q.tx_cnt;
    assign rx_count = q.rx_cnt;
    assign rx_events = q.rx_ev;
    assign tx_events = q.tx_ev;
    assign rx_dma_request = q.rx_dma;
    assign tx_dma_request = q.tx_dma;
    assign bus_busy = q.busy;
    assign wake_request = q.wake;
    assign sclk_out = q.sclk_o;
    assign sclk_oe = q.sclk_oe;
    assign mosi_out = q.dout;
    assign mosi_oe = q.mosi_oe;
    assign miso_out = q.dout;
    assign miso_oe = q.miso_oe;
    assign select_out = q.sel_o;
    assign select_oe = q.sel_oe;

endmodule

//--- core/csc_pkg.sv
// Shared constants and types of the configurable SPI controller.
// Assumes one core clock domain; every user of it writes csc_pkg::name.
package csc_pkg;

    // ==============================================================
    // Data and storage sizes
    localparam int CSC_DATA_W = 16;
    localparam int CSC_SLOTS = 16;
    localparam int CSC_PTR_W = 4;
    localparam int CSC_CNT_W = 5;
    localparam int CSC_BIT_W = 6;
    localparam int CSC_SEL_N = 4;
    localparam logic [CSC_CNT_W-1:0] CSC_DEPTH_WORDS = 5'h08;
    localparam logic [CSC_CNT_W-1:0] CSC_DEPTH_BYTES = 5'h10;

    // ==============================================================
    // Frame formats on frame_fmt
    localparam logic [1:0] CSC_FMT_CLASSIC = 2'h0;
    localparam logic [1:0] CSC_FMT_PULSE_COINCIDENT = 2'h1;
    localparam logic [1:0] CSC_FMT_PULSE_PRECEDING = 2'h2;
    localparam logic [1:0] CSC_FMT_HALF_DUPLEX = 2'h3;

    // ==============================================================
    // Event vector bit positions (rx side, tx side)
    localparam int CSC_EV_LEVEL = 0;
    localparam int CSC_EV_NOT_EMPTY = 1;
    localparam int CSC_EV_FULL = 2;
    localparam int CSC_EV_OVERFLOW = 3;
    localparam int CSC_EV_UNDERFLOW = 4;
    localparam int CSC_EV_BUS_ERR = 5;
    localparam int CSC_EV_NOT_FULL = 1;
    localparam int CSC_EV_EMPTY = 2;
    localparam int CSC_EV_DONE = 5;
    localparam int CSC_EV_N = 6;

    // ==============================================================
    // Timing: serial clock divider floor, in core clock cycles
    localparam logic [7:0] CSC_OVS_MIN = 8'h02;

    // ==============================================================
    // Sequencer states and complete module state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT,
        ST_GAP
    } csc_state_type;

    typedef struct packed {
        csc_state_type st;
        logic [7:0] div;
        logic ph;
        logic [CSC_BIT_W-1:0] bitcnt;
        logic [CSC_DATA_W-1:0] tx_word;
        logic [CSC_DATA_W-1:0] rx_word;
        logic sclk_prev;
        logic sel_prev;
        logic [CSC_SLOTS-1:0][CSC_DATA_W-1:0] txm;
        logic [CSC_SLOTS-1:0][CSC_DATA_W-1:0] rxm;
        logic [CSC_PTR_W-1:0] tx_wp;
        logic [CSC_PTR_W-1:0] tx_rp;
        logic [CSC_PTR_W-1:0] rx_wp;
        logic [CSC_PTR_W-1:0] rx_rp;
        logic [CSC_CNT_W-1:0] tx_cnt;
        logic [CSC_CNT_W-1:0] rx_cnt;
        logic [2:0] rx_stk;
        logic [2:0] tx_stk;
        logic [CSC_EV_N-1:0] rx_ev;
        logic [CSC_EV_N-1:0] tx_ev;
        logic rx_dma;
        logic tx_dma;
        logic busy;
        logic wake;
        logic tx_full;
        logic [CSC_DATA_W-1:0] rd_data;
        logic rd_valid;
        logic sclk_o;
        logic sclk_oe;
        logic dout;
        logic mosi_oe;
        logic miso_oe;
        logic [CSC_SEL_N-1:0] sel_o;
        logic sel_oe;
    } csc_regs_type;

    localparam csc_regs_type CSC_REGS_RESET = '0;

endpackage

//--- dv/configurable_spi_controller_test.sv
// Self-checking bench: master transfers, bit order, FIFO limits, events.
// Assumes csc_core, its checker and the peer model are compiled first.
`timescale 1ns/100ps
// =============================================================
// Bench
module configurable_spi_controller_test;
    logic core_clk = 1'b0, rst_n = 1'b0, enable = 1'b0, master_mode = 1'b1;
    logic [1:0] frame_fmt = 2'h0, active_select = 2'h0;
    logic clk_phase = 1'b0, clk_polarity = 1'b0, late_rx_sample_en = 1'b0;
    logic deep_sleep_wake_en = 1'b0, lsb_first = 1'b0;
    logic word_gap_select_release = 1'b0, packed_byte_fifo_en = 1'b0;
    logic continuous_serial_clock_en = 1'b0, tx_wr_req = 1'b0;
    logic rx_rd_req = 1'b0;
    logic [7:0] oversample = 8'h04, reply = 8'h35, got;
    logic [4:0] rx_width = 5'h08, tx_width = 5'h08, tx_count, rx_count;
    logic [4:0] rx_threshold = 5'h02, tx_threshold = 5'h04;
    logic [3:0] select_level_mask = 4'h0, select_out;
    logic [5:0] rx_event_mask = 6'h3F, tx_event_mask = 6'h3F, rx_events;
    logic [5:0] rx_event_clear = 6'h00, tx_event_clear = 6'h00, tx_events;
    logic [15:0] tx_wr_data = 16'h0000, rx_rd_data;
    logic rx_rd_valid, tx_full, rx_dma_request, tx_dma_request, bus_busy;
    logic wake_request, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out;
    logic miso_oe, select_oe, peer_miso;
    int err_total = 0, checks_done = 0, n;
    // Pull-down on the clock, pull-ups on MOSI and select; the peer drives MISO
    wire sclk_in = sclk_oe ? sclk_out : 1'b0;
    wire mosi_in = mosi_oe ? mosi_out : 1'b1;
    wire select_in = select_oe ? select_out[0] : 1'b1;
    wire miso_in = miso_oe ? miso_out : peer_miso;
    csc_core csc_core_inst (.*);
    csc_peer csc_peer_inst (.clk(core_clk), .sclk(sclk_in), .mosi(mosi_in),
        .sel_n(select_in), .reply(reply), .miso(peer_miso), .got(got));
    always #2.5 core_clk = ~core_clk;
    // =========================================================
    // Shared tasks
    task cyc;
        @(posedge core_clk);
        #1;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++) rev8[i] = d[7-i];
    endfunction
    // An idle edge after each request keeps strobes from toggling twice
    task push(input logic [7:0] d);
        tx_wr_req = 1'b1;
        tx_wr_data = {8'hC3, d};
        cyc;
        tx_wr_req = 1'b0;
        cyc;
    endtask
    task pop(input logic [15:0] exp);
        rx_rd_req = 1'b1;
        cyc;
        rx_rd_req = 1'b0;
        chk(rx_rd_valid, 16'h0001);
        chk(rx_rd_data, exp);
        cyc;
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // =========================================================
    // Scenarios
    task t_reset;
        chk(tx_count, 16'h0000);
        chk(rx_count | bus_busy, 16'h0000);
        chk(rx_events, 16'h0000);
        chk(tx_events, 16'h0007);
    endtask
    // One word each way; upper entry bits must not reach the wire
    task t_word(input logic [7:0] d);
        push(d);
        for (n = 0; n < 400 && rx_count == 5'h00; n++) cyc;
        chk(rx_count, 16'h0001);
        chk(got, lsb_first ? rev8(d) : d);
        pop({8'h00, lsb_first ? rev8(reply) : reply});
    endtask
    // Fill past full while idle, then drain with separated words
    task t_fill;
        enable = 1'b0;
        word_gap_select_release = 1'b1;
        tx_event_clear = 6'h38;
        cyc;
        tx_event_clear = 6'h00;
        chk(tx_events, 16'h0007);
        for (n = 0; n < 9; n++) push(8'h10 + n[7:0]);
        chk(tx_count, 16'h0008);
        chk({tx_full, tx_events[3], tx_dma_request}, 16'h0006);
        enable = 1'b1;
        for (n = 0; n < 2000 && (rx_count != 5'h08 || bus_busy); n++) cyc;
        cyc;
        chk(rx_count, 16'h0008);
        chk(got, 16'h0017);
        chk({rx_events[2], rx_dma_request, tx_events[5]}, 16'h0007);
        for (n = 0; n < 8; n++) pop(16'h0035);
        rx_rd_req = 1'b1;
        cyc;
        rx_rd_req = 1'b0;
        cyc;
        chk({rx_rd_valid, rx_events[4], rx_dma_request}, 16'h0002);
    endtask
    // Watchdog reckoned well beyond the expected run
    initial begin
        #100000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        cyc;
        cyc;
        t_reset;
        enable = 1'b1;
        t_word(8'hA1);
        enable = 1'b0;
        lsb_first = 1'b1;
        cyc;
        enable = 1'b1;
        t_word(8'h4E);
        lsb_first = 1'b0;
        t_fill;
        end_of_test;
    end
endmodule

//--- dv/csc_core_asserts.sv
// Port checker for the configurable SPI controller.
// Assumes one core clock domain; bound to every csc_core instance.
`timescale 1ns/100ps
// =============================================================
// Checker
module csc_core_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic master_mode,
    input wire logic [1:0] frame_fmt,
    input wire logic packed_byte_fifo_en,
    input wire logic [3:0] select_level_mask,
    input wire logic [1:0] active_select,
    input wire logic [4:0] rx_threshold,
    input wire logic [4:0] tx_threshold,
    input wire logic [5:0] tx_event_mask,
    input wire logic tx_wr_req,
    input wire logic rx_rd_req,
    input wire logic rx_rd_valid,
    input wire logic tx_full,
    input wire logic [4:0] tx_count,
    input wire logic [4:0] rx_count,
    input wire logic [5:0] tx_events,
    input wire logic rx_dma_request,
    input wire logic tx_dma_request,
    input wire logic bus_busy,
    input wire logic wake_request,
    input wire logic [3:0] select_out,
    input wire logic select_oe
);
    logic [1:0] settle_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Level checks wait out the registered lag after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) settle_q <= 2'h0;
        else if (settle_q != 2'h3) settle_q <= settle_q + 2'h1;
    end
    sequence s_good_read; rx_rd_req && rx_count != 5'h00; endsequence
    sequence s_full_push; tx_wr_req && tx_full && tx_event_mask[3]; endsequence
    a_read_valid: assert property (s_good_read |=> rx_rd_valid)
        else $error("good read gave no valid");
    a_empty_read: assert property (
        rx_rd_req && rx_count == 5'h00 |=> !rx_rd_valid)
        else $error("empty read gave valid");
    a_tx_ovf_flag: assert property (s_full_push |=> tx_events[3])
        else $error("tx overflow not flagged");
    a_full_depth: assert property (
        tx_full |-> tx_count == (packed_byte_fifo_en ? 5'h10 : 5'h08))
        else $error("tx full at wrong depth");
    a_rx_dma_level: assert property (
        settle_q == 2'h3 && $stable(rx_count) && $stable(rx_threshold)
        |-> rx_dma_request == (rx_count > rx_threshold))
        else $error("rx dma level wrong");
    a_tx_dma_level: assert property (
        settle_q == 2'h3 && $stable(tx_count) && $stable(tx_threshold)
        |-> tx_dma_request == (tx_count < tx_threshold))
        else $error("tx dma level wrong");
    a_one_select: assert property (
        select_oe |-> (~(select_out ^ select_level_mask) &
        ~(4'h1 << active_select)) == 4'h0)
        else $error("unpicked select line active");
    a_busy_follows_sel: assert property (
        select_oe && frame_fmt == csc_pkg::CSC_FMT_CLASSIC |->
        bus_busy == (select_out[active_select] ==
        select_level_mask[active_select]))
        else $error("busy differs from select");
    a_no_sel_write: assert property (
        master_mode && tx_wr_req && !bus_busy && tx_count == 5'h00
        |=> !bus_busy)
        else $error("select raised on fifo write");
    a_wake_master: assert property (
        master_mode && $stable(master_mode) |-> !wake_request)
        else $error("wake pulse in master");
endmodule
bind csc_core csc_core_asserts csc_core_asserts_inst (.*);

//--- dv/csc_peer.sv
// Behavioural SPI slave facing the controller, classic mode 0, MSB first.
// Assumes an active-low select; loads its reply at each selection.
`timescale 1ns/100ps
// =============================================================
// Peer
module csc_peer (
    input wire logic clk,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic junk = 1'b0;
    // Released line wanders so a stale bit never passes as data
    always @(posedge clk) if (sel_n) junk <= ~junk;
    always @(negedge sel_n) sh = reply;
    always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
    always @(negedge sclk) if (!sel_n) sh = {sh[6:0], 1'b0};
    assign miso = sel_n ? junk : sh[7];
endmodule
